// >>> hw/cfl_loader.sv
// Module: console file byte FIFO and control word loader
// -------------------------------------------------------------
// Byte FIFO
// -------------------------------------------------------------
module cfl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;
  logic             next_in_ready;

  // Handshake terms; ready is a flop that already tells the fill of the coming edge,
  // so a source that trusts it never offers into a full buffer and loses a byte
  always_comb begin
    push          = in_valid && in_ready;
    pop           = out_ready && (count != '0);
    next_wr_ptr   = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr   = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
    next_count    = (AW+1)'(count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    next_in_ready = (next_count != (AW+1)'(DEPTH));
  end

  // Pointer and ready registers; ready stays low for one edge after reset
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      count    <= '0;
      in_ready <= 1'b0;
    end else begin
      wr_ptr   <= next_wr_ptr;
      rd_ptr   <= next_rd_ptr;
      count    <= next_count;
      in_ready <= next_in_ready;
    end
  end

  // Storage is not reset; only the pointers and the count say what is valid
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  fifo_no_overflow_a: assert property (@(posedge clk) disable iff (!resetn)
    count <= (AW+1)'(DEPTH))
    else $error("byte buffer overfilled");

  fifo_ready_full_a: assert property (@(posedge clk) disable iff (!resetn)
    in_ready |-> (count != (AW+1)'(DEPTH)))
    else $error("byte buffer ready while full");
endmodule : cfl_fifo

// -------------------------------------------------------------
// Control word loader
// -------------------------------------------------------------
// How it works
// - Command 60 loads four bytes into control word
// - Command 60 keeps processor clock stopped
// - Command C0 gathers four bytes then starts clock
// - Held control word executes with data operand
// - Command bit 7 selects external data source
// - Destination bits zero select local-store word zero
// - Storage address bypassed from result register
module cfl_loader #(
  parameter int FIFO_DEPTH = cfl_pkg::CFL_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          resetn,
  // Disk byte stream
  input  wire logic                          disk_valid,
  output logic                               disk_ready,
  input  wire logic [cfl_pkg::CFL_BYTE_W-1:0] disk_byte,
  // Command byte, one cycle strobe while idle
  input  wire logic                          cmd_valid,
  input  wire logic [cfl_pkg::CFL_BYTE_W-1:0] cmd_byte,
  // Processor datapath
  input  wire logic [cfl_pkg::CFL_WORD_W-1:0] result_reg,
  input  wire logic                          exec_done,
  output logic                               cpu_clock_run,
  output logic [cfl_pkg::CFL_WORD_W-1:0]      control_word,
  output logic [cfl_pkg::CFL_WORD_W-1:0]      console_file_data_reg,
  output logic                               src_external,
  output logic                               dst_local_store_word_zero,
  output logic [cfl_pkg::CFL_WORD_W-1:0]      cs_address,
  output logic                               busy
);
  import cfl_pkg::*;

  cfl_state_e             state;
  cfl_state_e             next_state;
  logic [CFL_CNT_W-1:0]   cnt;
  logic [CFL_CNT_W-1:0]   next_cnt;
  logic [CFL_BYTE_W-1:0]  cmd_reg;
  logic [CFL_BYTE_W-1:0]  next_cmd_reg;
  logic [CFL_WORD_W-1:0]  next_control_word;
  logic [CFL_WORD_W-1:0]  next_data_reg;
  logic                   next_run;
  logic                   next_src;
  logic                   next_dst0;
  logic [CFL_WORD_W-1:0]  next_cs_address;
  logic                   f_valid;
  logic                   f_ready;
  logic [CFL_BYTE_W-1:0]  f_data;
  logic                   take;

  // Disk bytes are buffered so the drive can run ahead of the loader;
  // the drive's ready comes straight from the buffer's own ready flop
  cfl_fifo #(
    .WIDTH (CFL_BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .resetn    (resetn),
    .in_valid  (disk_valid),
    .in_ready  (disk_ready),
    .in_data   (disk_byte),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  // Bytes are drained only while a load is in progress
  assign f_ready = (state == CFL_LOAD_CW) || (state == CFL_LOAD_DATA);
  assign take    = f_ready && f_valid;

  // Next-state logic for the loader
  always_comb begin
    next_state        = state;
    next_cnt          = cnt;
    next_cmd_reg      = cmd_reg;
    next_control_word = control_word;
    next_data_reg     = console_file_data_reg;
    next_run          = cpu_clock_run;
    next_src          = src_external;
    next_dst0         = dst_local_store_word_zero;
    next_cs_address   = cs_address;
    unique case (state)
      CFL_IDLE: begin
        next_run = 1'b0;
        if (cmd_valid && (cmd_byte == CFL_CMD_DISK_TO_CW)) begin
          next_state   = CFL_LOAD_CW;
          next_cmd_reg = cmd_byte;
          next_cnt     = CFL_CNT_ZERO;
        end else if (cmd_valid && (cmd_byte == CFL_CMD_EXEC_DATA)) begin
          next_state   = CFL_LOAD_DATA;
          next_cmd_reg = cmd_byte;
          next_cnt     = CFL_CNT_ZERO;
        end
      end
      CFL_LOAD_CW: begin
        next_run = 1'b0;
        if (take) begin
          next_control_word = {control_word[CFL_WORD_W-CFL_BYTE_W-1:0], f_data};
          next_cnt          = CFL_CNT_W'(cnt + 1'b1);
          if (cnt == CFL_CNT_LAST) begin
            next_state = CFL_IDLE;
          end
        end
      end
      CFL_LOAD_DATA: begin
        if (take) begin
          next_data_reg = {console_file_data_reg[CFL_WORD_W-CFL_BYTE_W-1:0], f_data};
          next_cnt      = CFL_CNT_W'(cnt + 1'b1);
          if (cnt == CFL_CNT_LAST) begin
            next_state = CFL_EXEC;
            next_run   = 1'b1;
            next_src   = cmd_reg[CFL_SRC_BIT];
            next_dst0  = (cmd_reg[CFL_DST_MSB:0] == CFL_DST_LSW0);
            next_cs_address = result_reg;
          end
        end
      end
      CFL_EXEC: begin
        next_run = 1'b1;
        if (dst_local_store_word_zero) begin
          next_cs_address = result_reg;
        end
        if (exec_done) begin
          next_state = CFL_IDLE;
          next_run   = 1'b0;
        end
      end
    endcase
  end

  // Loader registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state                     <= CFL_IDLE;
      cnt                       <= CFL_CNT_ZERO;
      cmd_reg                   <= CFL_CMD_RESET;
      control_word              <= CFL_WORD_RESET;
      console_file_data_reg     <= CFL_WORD_RESET;
      cpu_clock_run             <= 1'b0;
      src_external              <= 1'b0;
      dst_local_store_word_zero <= 1'b0;
      cs_address                <= CFL_WORD_RESET;
      busy                      <= 1'b0;
    end else begin
      state                     <= next_state;
      cnt                       <= next_cnt;
      cmd_reg                   <= next_cmd_reg;
      control_word              <= next_control_word;
      console_file_data_reg     <= next_data_reg;
      cpu_clock_run             <= next_run;
      src_external              <= next_src;
      dst_local_store_word_zero <= next_dst0;
      cs_address                <= next_cs_address;
      busy                      <= (next_state != CFL_IDLE);
    end
  end

  // clock stays stopped while loading a word
  cw_clock_stop_a: assert property (@(posedge clk) disable iff (!resetn)
    (state == CFL_LOAD_CW) |-> !cpu_clock_run)
    else $error("clock ran during control word load");

  // word changes only during a word load
  cw_load_only_a: assert property (@(posedge clk) disable iff (!resetn)
    (state != CFL_LOAD_CW) |=> $stable(control_word) || $past(state) == CFL_LOAD_CW)
    else $error("control word changed outside load");

  cw_end_idle_a: assert property (@(posedge clk) disable iff (!resetn)
    (state == CFL_LOAD_CW && take && cnt == CFL_CNT_LAST) |=> state == CFL_IDLE)
    else $error("word load did not end after four bytes");

  data_start_clk_a: assert property (@(posedge clk) disable iff (!resetn)
    (state == CFL_LOAD_DATA && take && cnt == CFL_CNT_LAST) |=> cpu_clock_run && state == CFL_EXEC)
    else $error("clock not started after data");

  data_no_clk_a: assert property (@(posedge clk) disable iff (!resetn)
    (state == CFL_LOAD_DATA) |-> !cpu_clock_run)
    else $error("clock ran before data complete");

  exec_word_held_a: assert property (@(posedge clk) disable iff (!resetn)
    (state == CFL_EXEC) |-> $stable(control_word) && cpu_clock_run)
    else $error("control word not held in execution");

  src_select_a: assert property (@(posedge clk) disable iff (!resetn)
    (state == CFL_EXEC) |-> src_external == cmd_reg[CFL_SRC_BIT])
    else $error("source select mismatch");

  dst_select_a: assert property (@(posedge clk) disable iff (!resetn)
    (state == CFL_EXEC) |-> dst_local_store_word_zero == (cmd_reg[CFL_DST_MSB:0] == CFL_DST_LSW0))
    else $error("destination select mismatch");

  cs_bypass_a: assert property (@(posedge clk) disable iff (!resetn)
    (state == CFL_EXEC && dst_local_store_word_zero) |=> cs_address == $past(result_reg))
    else $error("storage address not bypassed");

  // each taken byte enters at the bottom
  cw_byte_shift_a: assert property (@(posedge clk) disable iff (!resetn)
    (state == CFL_LOAD_CW && take) |=>
      control_word == {$past(control_word[CFL_WORD_W-CFL_BYTE_W-1:0]), $past(f_data)})
    else $error("control word byte not shifted in");

  idle_clk_off_a: assert property (@(posedge clk) disable iff (!resetn)
    (state == CFL_IDLE) |-> !cpu_clock_run)
    else $error("clock ran while loader idle");

  exec_stop_a: assert property (@(posedge clk) disable iff (!resetn)
    (state == CFL_EXEC && exec_done) |=> !cpu_clock_run && state == CFL_IDLE)
    else $error("clock not stopped after execution done");
endmodule : cfl_loader

// >>> hw/cfl_pkg.sv
// Package: constants and types for the console file control word loader
package cfl_pkg;
  // -------------------------------------------------------------
  // Command codes
  // -------------------------------------------------------------
  localparam logic [7:0] CFL_CMD_DISK_TO_CW = 8'h60;
  localparam logic [7:0] CFL_CMD_EXEC_DATA  = 8'hc0;
  // -------------------------------------------------------------
  // Field positions and widths
  // -------------------------------------------------------------
  localparam int CFL_BYTE_W      = 8;
  localparam int CFL_WORD_BYTES  = 4;
  localparam int CFL_WORD_W      = 32;
  localparam int CFL_CNT_W       = 2;
  localparam int CFL_SRC_BIT     = 7;
  localparam int CFL_DST_MSB     = 5;
  localparam int CFL_DST_W       = 6;
  localparam logic [1:0] CFL_CNT_LAST = 2'h3;
  localparam logic [1:0] CFL_CNT_ZERO = 2'h0;
  localparam logic [5:0] CFL_DST_LSW0 = 6'h00;
  localparam logic [7:0] CFL_CMD_RESET = 8'h00;
  localparam logic [31:0] CFL_WORD_RESET = 32'h0000_0000;
  localparam int CFL_FIFO_DEPTH  = 16;
  // -------------------------------------------------------------
  // Loader states
  // -------------------------------------------------------------
  typedef enum logic [1:0] {
    CFL_IDLE,
    CFL_LOAD_CW,
    CFL_LOAD_DATA,
    CFL_EXEC
  } cfl_state_e;
endpackage : cfl_pkg

// >>> sim/cfl_disk_model.sv
// Console diskette drive model offering microcode bytes on a valid/ready handshake
module cfl_disk_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Byte stream
  input  wire logic       disk_ready,
  output logic            disk_valid,
  output logic [7:0]      disk_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] q[$];
  int         gap = 0;
  int         wait_cnt;

  // Queue a byte for the drive to read
  function automatic void push(input logic [7:0] b);
    q.push_back(b);
  endfunction : push

  // A refused byte is held; an idle line toggles so a stale byte never looks fresh
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      disk_valid <= 1'b0;
      disk_byte  <= 8'h00;
      wait_cnt   <= 0;
    end else if (disk_valid && !disk_ready) begin
      disk_valid <= 1'b1;
    end else begin
      if (disk_valid) begin
        void'(q.pop_front());
      end
      if (wait_cnt != 0 || q.size() == 0) begin
        disk_valid <= 1'b0;
        disk_byte  <= ~disk_byte;
        wait_cnt   <= (wait_cnt != 0) ? wait_cnt - 1 : 0;
      end else begin
        disk_valid <= 1'b1;
        disk_byte  <= q[0];
        wait_cnt   <= gap;
      end
    end
  end
endmodule : cfl_disk_model

// >>> sim/tb_top.sv
// Self-checking testbench for the console file control word loader
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cfl_pkg::*;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        disk_valid, disk_ready, cmd_valid, exec_done;
  logic [7:0]  disk_byte, cmd_byte;
  logic [31:0] result_reg, control_word, console_file_data_reg, cs_address;
  logic        cpu_clock_run, src_external, dst_local_store_word_zero, busy;
  int          fails = 0;
  int          samples_checked = 0;

  always #5 clk = ~clk;

  cfl_disk_model u_disk (.clk(clk), .resetn(resetn), .disk_ready(disk_ready), .disk_valid(disk_valid),
    .disk_byte(disk_byte));
  cfl_loader #(.FIFO_DEPTH(16)) u_dut (.clk(clk), .resetn(resetn), .disk_valid(disk_valid),
    .disk_ready(disk_ready), .disk_byte(disk_byte), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .result_reg(result_reg), .exec_done(exec_done), .cpu_clock_run(cpu_clock_run),
    .control_word(control_word), .console_file_data_reg(console_file_data_reg),
    .src_external(src_external), .dst_local_store_word_zero(dst_local_store_word_zero),
    .cs_address(cs_address), .busy(busy));

  // -------------------------------------------------------------
  // Shared tasks
  // -------------------------------------------------------------
  task automatic complete_run();
    if (fails == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  task automatic compare(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : compare

  // One-cycle command strobe launched at an edge
  task automatic send_cmd(input logic [7:0] c);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_byte  <= c;
    @(posedge clk);
    cmd_valid <= 1'b0;
  endtask : send_cmd

  // Bounded wait for run high or idle, sampled after the edge settles
  task automatic wait_for(input bit want_run);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while ((want_run ? cpu_clock_run !== 1'b1 : busy !== 1'b0) && n < 60);
    compare("wait_bound", 32'h1, {31'h0, n < 60});
  endtask : wait_for

  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  // Load a word without running, then execute a move with disk data
  task automatic exec_word(input logic [31:0] cw, input logic [31:0] data, input logic [31:0] res);
    int i;
    @(posedge clk);
    result_reg <= res;
    for (i = 3; i >= 0; i--) u_disk.push(cw[i*8 +: 8]);
    send_cmd(8'h60);
    wait_for(1'b0);
    compare("control_word", cw, control_word);
    compare("run_after_load", 32'h0, {31'h0, cpu_clock_run});
    for (i = 3; i >= 0; i--) u_disk.push(data[i*8 +: 8]);
    send_cmd(8'hc0);
    send_cmd(8'h60); // Refused while busy
    wait_for(1'b1);
    compare("data_reg", data, console_file_data_reg);
    compare("held_word", cw, control_word);
    compare("src_external", 32'h1, {31'h0, src_external});
    compare("dst_word_zero", 32'h1, {31'h0, dst_local_store_word_zero});
    compare("cs_address", res, cs_address);
    @(posedge clk);
    exec_done <= 1'b1;
    @(posedge clk);
    exec_done <= 1'b0;
    #1;
    compare("run_after_done", 32'h0, {31'h0, cpu_clock_run});
    compare("busy_after_done", 32'h0, {31'h0, busy});
  endtask : exec_word

  // Bytes queued before the commands fill the buffer, then drain word by word
  task automatic prefill();
    int w;
    int j;
    logic [31:0] exp;
    u_disk.gap = 0;
    for (j = 0; j < 16; j++) u_disk.push(8'h10 + 8'(j));
    repeat (24) @(posedge clk);
    #1;
    compare("ready_full", 32'h0, {31'h0, disk_ready});
    for (w = 0; w < 4; w++) begin
      exp = 32'h0;
      for (j = 0; j < 4; j++) exp = {exp[23:0], 8'h10 + 8'(4 * w + j)};
      send_cmd(8'h60);
      wait_for(1'b0);
      compare("queued_word", exp, control_word);
    end
    compare("ready_empty", 32'h1, {31'h0, disk_ready});
  endtask : prefill

  // -------------------------------------------------------------
  // Main sequence and watchdog
  // -------------------------------------------------------------
  initial begin
    cmd_valid  = 1'b0;
    cmd_byte   = 8'h00;
    result_reg = 32'h0;
    exec_done  = 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    #1;
    compare("reset_word", 32'h0, control_word);
    u_disk.gap = 2;
    exec_word(32'h38800f00, 32'h00008000, 32'h00000000);
    exec_word(32'h48c80000, 32'ha55a3cc3, 32'h00000400);
    send_cmd(8'h40);
    @(posedge clk);
    #1;
    compare("busy_other_cmd", 32'h0, {31'h0, busy});
    prefill();
    complete_run();
  end

  initial begin
    #100us;
    fails++;
    complete_run();
  end
endmodule : tb_top
